// ===== pkg/serial_shift_defs.svh
`ifndef SERIAL_SHIFT_DEFS_SVH
`define SERIAL_SHIFT_DEFS_SVH

// Register offsets (nibble-wide port, printed offsets)
`define OFS_PIN_FUNC 12'h004
`define OFS_MODE_CTRL 12'h005
`define OFS_DATA_LOW 12'h006
`define OFS_DATA_HIGH 12'h007
`define OFS_DIV_IDLE 12'h025
`define OFS_STATUS 12'h003

// Field positions
`define MODE_INTERNAL_BIT 3
`define MODE_RATIO_MSB 2
`define PIN_SO_BIT 0
`define PIN_SI_BIT 1
`define DIV_SELECT_BIT 0
`define DIV_IDLE_BIT 1
`define STATUS_IRQ_BIT 2

// Reset values
`define MODE_RESET 4'h0
`define PIN_RESET 4'h0
`define DIV_RESET 4'h0

// Mode setting takes effect two instruction cycles after the write
`define MODE_DELAY_CYC 2

// Instruction cycle length in system clocks
`define INSTR_CYCLE_CLKS 4

`endif

// ===== pkg/serial_shift_pkg.sv
package serial_shift_pkg;

  typedef enum logic [1:0] {
    ST_START_WAIT = 2'b00,
    ST_CLOCK_WAIT = 2'b01,
    ST_TRANSFER = 2'b11,
    ST_CONT_CLOCK = 2'b10
  } xfer_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic so_o;
    logic so_oe;
  } pin_out_s;

endpackage

// ===== core/clock_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser with rise and fall pulses taken from the second stage
module clock_sync (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Asynchronous level
  input wire logic i_level,
  // Synchronised level and edges
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.meta = i_level;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.sync;
  assign o_rise = st_q.sync & ~st_q.prev;
  assign o_fall = ~st_q.sync & st_q.prev;

endmodule

// ===== core/ratio_divider.sv
`timescale 1ns/1ps
`include "serial_shift_defs.svh"
// Prescaler: internal transmit clock phase enables from instruction cycles
module ratio_divider #(
  parameter int CNT_W = 14
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Control
  input wire logic i_run,
  input wire logic [2:0] i_ratio,
  input wire logic i_div_select,
  // Half-period tick of the internal transmit clock
  output logic o_tick
);

  typedef struct packed {
    logic [1:0] cyc;
    logic [CNT_W-1:0] cnt;
    logic tick;
  } div_s;

  div_s st_q;
  div_s st_d;

  // Half period in instruction cycles equals the prescaler ratio
  function automatic logic [CNT_W-1:0] half_period(
    input logic [2:0] r,
    input logic sel
  );
    logic [CNT_W-1:0] base;
    base = '0;
    case (r)
      3'h0: base = CNT_W'(2048);
      3'h1: base = CNT_W'(512);
      3'h2: base = CNT_W'(128);
      3'h3: base = CNT_W'(32);
      3'h4: base = CNT_W'(8);
      3'h5: base = CNT_W'(2);
      default: base = CNT_W'(2);
    endcase
    return sel ? base << 1 : base;
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!i_run) begin
      st_d.cyc = '0;
      st_d.cnt = '0;
    end else if (st_q.cyc == 2'(`INSTR_CYCLE_CLKS - 1)) begin
      st_d.cyc = '0;
      if (st_q.cnt >= half_period(i_ratio, i_div_select) - 1'b1) begin
        st_d.cnt = '0;
        st_d.tick = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end else begin
      st_d.cyc = st_q.cyc + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;

endmodule

// ===== core/serial_shift_interface.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "serial_shift_defs.svh"
// What this block does
// - Mode bit 3 set: pin bits 1:0 pick clock, send, receive, both.
// - Clock pin follows mode register; serial-out enable follows pin register bit 0.
// - Two nibble registers hold send data and received data, shifted.
// - Serial-out level low from reset until first bit or idle control.
// - Start clears counter to 000; it counts transmit clock rises.
// - Eight rises or cut-off: counter 000, flag set; eight rises on external clock return to clock-wait, else start-wait.
// - Transmit clock is external or an internal prescaler selection.
// - Divide-select clear: ratios 2048 down to 2, period twice ratio.
// - Divide-select set: ratios 4096 down to 4.
// - Reset gives start-wait, which ignores transmit clock edges.
// - Start in start-wait moves to clock-wait.
// - First fall in clock-wait drives out bit 0, enters transfer.
// - Continuous mode with internal clock goes to continuous output.
// - Mode write in clock-wait returns to start-wait.
// - Start during transfer clears counter and returns to clock-wait.
// - Continuous output state only reachable with internal clock.
// - Output LSB first on falls; input sampled LSB first on rises.
// - Mode write during transfer aborts, clears counter, sets flag.
// - Mode write takes effect two instruction cycles later.
module serial_shift_interface
  import serial_shift_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Register port
  input serial_shift_pkg::reg_req_s i_req,
  output logic [3:0] o_rdata,
  // CPU start instruction and flag clear
  input wire logic i_start_pulse,
  input wire logic i_flag_clear,
  output logic o_serial_irq_flag,
  // Serial pins
  input wire logic i_sck,
  input wire logic i_si,
  output serial_shift_pkg::pin_out_s o_pins
);
  import serial_shift_pkg::*;

  typedef struct packed {
    xfer_state_e state;
    logic [2:0] count;
    logic [7:0] shift;
    logic [3:0] mode;
    logic [3:0] mode_new;
    logic [3:0] mode_wait;
    logic [3:0] pin_func;
    logic [3:0] div_idle;
    logic flag;
    logic int_clk;
    logic [3:0] rdata;
    pin_out_s pins;
  } core_s;

  core_s st_q;
  core_s st_d;

  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic tick;
  logic clk_rise;
  logic clk_fall;
  logic internal;
  logic running;
  logic wr_mode;

  ////////////////////////////////////////////////////////////////////////
  // Sync external clock
  clock_sync u_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_level(i_sck),
    .o_level(ext_level),
    .o_rise(ext_rise),
    .o_fall(ext_fall)
  );

  assign internal = st_q.mode[`MODE_INTERNAL_BIT];
  assign running = internal && (st_q.state != ST_START_WAIT);

  ratio_divider #(.CNT_W(14)) u_div (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_run(running),
    .i_ratio(st_q.mode[`MODE_RATIO_MSB:0]),
    .i_div_select(st_q.div_idle[`DIV_SELECT_BIT]),
    .o_tick(tick)
  );

  // Internal clock idles high; a tick toggles it
  assign clk_fall = internal ? (tick && st_q.int_clk) : ext_fall;
  assign clk_rise = internal ? (tick && !st_q.int_clk) : ext_rise;
  assign wr_mode = i_req.wr && (i_req.addr == `OFS_MODE_CTRL);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.rdata = 4'h0;
    if (st_q.mode_wait != 4'h0) begin
      st_d.mode_wait = st_q.mode_wait - 4'h1;
      if (st_q.mode_wait == 4'h1) begin
        st_d.mode = st_q.mode_new;
      end
    end
    if (running && tick) begin
      st_d.int_clk = ~st_q.int_clk;
    end
    if (st_q.state == ST_START_WAIT) begin
      st_d.int_clk = 1'b1;
    end
    case (st_q.state)
      ST_START_WAIT: begin
        if (i_start_pulse) begin
          st_d.count = 3'h0;
          st_d.state = ST_CLOCK_WAIT;
        end
      end
      ST_CLOCK_WAIT: begin
        if (i_start_pulse) begin
          st_d.count = 3'h0;
        end else if (clk_fall) begin
          if (internal && st_q.pin_func[1:0] == 2'b00) begin
            st_d.state = ST_CONT_CLOCK;
          end else begin
            st_d.state = ST_TRANSFER;
            st_d.pins.so_o = st_q.shift[0];
          end
        end
      end
      ST_TRANSFER: begin
        if (i_start_pulse) begin
          st_d.count = 3'h0;
          st_d.state = ST_CLOCK_WAIT;
        end else begin
          if (clk_fall) begin
            st_d.pins.so_o = st_q.shift[0];
          end
          if (clk_rise) begin
            // Sample on rise, shift toward LSB
            st_d.shift = {i_si, st_q.shift[7:1]};
            st_d.count = st_q.count + 3'h1;
            if (st_q.count == 3'h7) begin
              st_d.count = 3'h0;
              st_d.flag = 1'b1;
              st_d.state = internal ? ST_START_WAIT : ST_CLOCK_WAIT;
            end
          end
        end
      end
      ST_CONT_CLOCK: begin
        st_d.state = ST_CONT_CLOCK;
      end
      default: begin
        st_d.state = ST_START_WAIT;
      end
    endcase
    ////////////////////////////////////////////////////////////////////////
    // Register writes
    if (i_req.wr) begin
      case (i_req.addr)
        `OFS_PIN_FUNC: st_d.pin_func = i_req.wdata;
        `OFS_DATA_LOW: st_d.shift[3:0] = i_req.wdata;
        `OFS_DATA_HIGH: st_d.shift[7:4] = i_req.wdata;
        `OFS_DIV_IDLE: begin
          // Divider bits are frozen while data moves
          if (st_q.state != ST_TRANSFER) begin
            st_d.div_idle = i_req.wdata;
            st_d.pins.so_o = i_req.wdata[`DIV_IDLE_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (wr_mode) begin
      st_d.mode_new = i_req.wdata;
      st_d.mode_wait = 4'(`MODE_DELAY_CYC * `INSTR_CYCLE_CLKS);
      st_d.count = 3'h0;
      st_d.state = ST_START_WAIT;
      if (st_q.state == ST_TRANSFER) begin
        st_d.flag = 1'b1;
      end
    end
    // Hardware set wins over software clear
    if (i_flag_clear && !(st_d.flag && !st_q.flag)) begin
      st_d.flag = 1'b0;
    end
    if (i_req.rd) begin
      case (i_req.addr)
        `OFS_DATA_LOW: st_d.rdata = st_q.shift[3:0];
        `OFS_DATA_HIGH: st_d.rdata = st_q.shift[7:4];
        `OFS_STATUS: st_d.rdata = {1'b0, st_q.flag, st_q.state};
        default: st_d.rdata = 4'h0;
      endcase
    end
    st_d.pins.sck_oe = st_d.mode[`MODE_INTERNAL_BIT];
    st_d.pins.sck_o = st_d.int_clk;
    st_d.pins.so_oe = st_d.pin_func[`PIN_SO_BIT];
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_q <= '0;
      st_q.state <= ST_START_WAIT;
      st_q.mode <= `MODE_RESET;
      st_q.mode_new <= `MODE_RESET;
      st_q.pin_func <= `PIN_RESET;
      st_q.div_idle <= `DIV_RESET;
      st_q.int_clk <= 1'b1;
      st_q.pins.sck_o <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;
  assign o_serial_irq_flag = st_q.flag;
  assign o_pins = st_q.pins;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  start_wait_a: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (st_q.state == ST_START_WAIT && i_start_pulse && !wr_mode)
      |=> (st_q.state == ST_CLOCK_WAIT && st_q.count == 3'h0))
    else $error("start in start-wait did not reach clock-wait");

  byte_done_a: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (st_q.state == ST_TRANSFER && st_q.count == 3'h7 && clk_rise
      && !i_start_pulse && !wr_mode)
      |=> (st_q.count == 3'h0 && st_q.flag))
    else $error("eighth rise did not end the byte");

  mode_abort_a: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (wr_mode && st_q.state == ST_TRANSFER)
      |=> (st_q.flag && st_q.state == ST_START_WAIT))
    else $error("mode write did not abort transfer");

  cont_clock_a: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (st_q.state == ST_CONT_CLOCK) |-> internal)
    else $error("continuous output with external clock");

  restart_a: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (st_q.state == ST_TRANSFER && i_start_pulse && !wr_mode)
      |=> (st_q.state == ST_CLOCK_WAIT && st_q.count == 3'h0))
    else $error("start in transfer did not restart");

  mode_delay_a: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (wr_mode && st_q.mode_wait == 4'h0)
      |=> ##8 (st_q.mode == $past(st_q.mode_new, 1)))
    else $error("mode did not take effect after delay");

  idle_ignore_a: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (st_q.state == ST_START_WAIT && !i_start_pulse && !i_req.wr)
      |=> $stable(st_q.shift))
    else $error("start-wait shifted data");

  clk_wait_mode_a: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (wr_mode && st_q.state == ST_CLOCK_WAIT) |=> (st_q.state == ST_START_WAIT))
    else $error("mode write in clock-wait kept state");

  // Read data stands only in the cycle after a read strobe
  rdata_idle_a: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (!i_req.rd) |=> (o_rdata == 4'h0))
    else $error("read data shown without a read");

endmodule

// ===== verif/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire logic i_mclk,
  // Pin levels
  input wire logic i_sck,
  input wire logic i_so,
  output logic o_sck,
  output logic o_si,
  output logic [7:0] o_got
);
  logic [7:0] tx;
  logic prev;
  int idx;
  int idle;
  initial begin
    o_sck = 1'b1;
    o_si = 1'b0;
    o_got = '0;
    tx = '0;
    prev = 1'b1;
    idx = 0;
    idle = 99;
  end
  //////////////////////////////////////////////////////////////////////////
  // LSB first shifting
  always @(posedge i_mclk) begin
    prev <= i_sck;
    idle <= (idle < 99) ? idle + 1 : idle;
    if (prev && !i_sck) begin
      o_si <= tx[idx[2:0]];
      idx <= idx + 1;
      idle <= 99;
    end else if (!prev && i_sck) begin
      o_got <= {i_so, o_got[7:1]};
      idle <= 0;
    end else if (idle == 40) begin
      // Hold over: a stale bit must not look valid
      o_si <= ~o_si;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic load(input logic [7:0] b);
    tx = b;
    idx = 0;
  endtask
  // Clock idles high and stands still between frames
  task automatic frame(input logic [7:0] b, input int nbits);
    load(b);
    repeat (nbits) begin
      @(posedge i_mclk) o_sck <= 1'b0;
      repeat (8) @(posedge i_mclk);
      o_sck <= 1'b1;
      repeat (8) @(posedge i_mclk);
    end
  endtask
endmodule

// ===== verif/serial_shift_interface_test.sv
`timescale 1ns/1ps
`include "serial_shift_defs.svh"
`define CHECK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module serial_shift_interface_test;
  import serial_shift_pkg::*;
  logic i_mclk = 0;
  logic i_reset = 1;
  logic start = 0;
  logic clr = 0;
  reg_req_s req = '0;
  logic [3:0] rdata;
  logic [3:0] v;
  logic flag;
  pin_out_s pins;
  logic sck_ext;
  logic si;
  logic sck_w;
  logic [7:0] got;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  // Pin level: device drives when enabled, else the peer
  assign sck_w = pins.sck_oe ? pins.sck_o : sck_ext;
  serial_shift_interface serial_shift_interface_i (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_req(req), .o_rdata(rdata),
    .i_start_pulse(start), .i_flag_clear(clr),
    .o_serial_irq_flag(flag), .i_sck(sck_w), .i_si(si), .o_pins(pins));
  serial_peer serial_peer_i (
    .i_mclk(i_mclk), .i_sck(sck_w), .i_so(pins.so_o), .o_sck(sck_ext),
    .o_si(si), .o_got(got));
  initial forever #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    @(posedge i_mclk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge i_mclk) req <= '{a, 4'h0, 1'b0, 1'b1};
    @(posedge i_mclk) req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse(input bit s);
    @(posedge i_mclk) begin
      start <= s;
      clr <= !s;
    end
    @(posedge i_mclk) begin
      start <= 1'b0;
      clr <= 1'b0;
    end
  endtask
  // Mode setting lands eight clocks after the write
  task automatic mode(input logic [3:0] d);
    wr(`OFS_MODE_CTRL, d);
    repeat (10) @(posedge i_mclk);
  endtask
  task automatic wait_st(input logic [3:0] e, input logic [3:0] m);
    n = 0;
    do begin
      rd(`OFS_STATUS);
      n++;
    end while ((v & m) !== e && n < 1000);
    `CHECK("status", e, v & m)
  endtask
  task automatic fall();
    wait (pins.sck_o === 1'b1);
    wait (pins.sck_o === 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_mclk);
    i_reset <= 1'b0;
    wait_st(4'h0, 4'hF);
    wr(`OFS_PIN_FUNC, 4'h3);
    wr(`OFS_DIV_IDLE, 4'h2);
    rd(12'h0FF);
    `CHECK("unmapped", 4'h0, v)
    `CHECK("so idle", 2'b11, {pins.so_oe, pins.so_o})
    wr(`OFS_DIV_IDLE, 4'h0);
    @(posedge i_mclk) #1;
    `CHECK("so idle", 2'b10, {pins.so_oe, pins.so_o})
    mode(4'h0);
    serial_peer_i.frame(8'hFF, 8);
    wait_st(4'h0, 4'hF);
    $display("test idle done");
    wr(`OFS_DATA_LOW, 4'h5);
    wr(`OFS_DATA_HIGH, 4'hA);
    pulse(1);
    wait_st(4'h1, 4'hF);
    serial_peer_i.frame(8'h3C, 8);
    wait_st(4'h5, 4'hF);
    `CHECK("irq flag", 1'b1, flag)
    `CHECK("peer byte", 8'hA5, got)
    rd(`OFS_DATA_LOW);
    `CHECK("data low", 4'hC, v)
    rd(`OFS_DATA_HIGH);
    `CHECK("data high", 4'h3, v)
    pulse(0);
    serial_peer_i.frame(8'h00, 3);
    wait_st(4'h3, 4'hF);
    `CHECK("irq clear", 1'b0, flag)
    pulse(1);
    wait_st(4'h1, 4'h3);
    mode(4'h0);
    wait_st(4'h0, 4'h3);
    pulse(0);
    pulse(1);
    serial_peer_i.frame(8'h00, 3);
    wr(`OFS_MODE_CTRL, 4'h0);
    wait_st(4'h4, 4'hF);
    `CHECK("irq abort", 1'b1, flag)
    pulse(0);
    repeat (10) @(posedge i_mclk);
    pulse(1);
    serial_peer_i.frame(8'h96, 7);
    wait_st(4'h3, 4'hF);
    serial_peer_i.frame(8'h96, 1);
    wait_st(4'h5, 4'hF);
    pulse(0);
    mode(4'h0);
    $display("test external done");
    for (int s = 0; s < 2; s++) begin
      for (int c = 4; c < 6; c++) begin
        wr(`OFS_DIV_IDLE, {3'b000, s[0]});
        mode({1'b1, c[2:0]});
        serial_peer_i.load(8'h69);
        pulse(1);
        fall();
        n = cyc;
        fall();
        `CHECK("period", (2048 >> (2 * c)) << s << 3, cyc - n)
        wait_st(4'h4, 4'hF);
        `CHECK("sck drive", 1'b1, pins.sck_oe)
        rd(`OFS_DATA_LOW);
        `CHECK("rx low", 4'h9, v)
        rd(`OFS_DATA_HIGH);
        `CHECK("rx high", 4'h6, v)
        pulse(0);
        $display("test internal done");
      end
    end
    wr(`OFS_PIN_FUNC, 4'h0);
    mode(4'hD);
    pulse(1);
    wait_st(4'h2, 4'hF);
    mode(4'hD);
    wait_st(4'h0, 4'hF);
    mode(4'h0);
    pulse(1);
    serial_peer_i.frame(8'h00, 1);
    wait_st(4'h3, 4'hF);
    $display("test continuous done");
    report_and_stop();
  end
endmodule
